// ==== dv/pcsb_fabric_model.sv ====
`timescale 1ns/1ps
module pcsb_fabric_model (
    input wire logic core_clk,
    input wire logic sendReq,
    input wire logic simpOn,
    input wire logic isCtrl,
    input wire logic forceOn,
    input wire logic wantNeg,
    input wire logic flip,
    input wire logic [pcsb_pkg::NLANE-1:0] rmFullAsync,
    input wire logic [pcsb_pkg::NLANE-1:0] rmEmptyAsync,
    output pcsb_pkg::pcsb_txin_s txIn,
    output logic txForceDispPin,
    output logic txDispValPin,
    output logic [pcsb_pkg::NLANE-1:0] rmFullSync,
    output logic [pcsb_pkg::NLANE-1:0] rmEmptySync
);
    logic [2*pcsb_pkg::NLANE-1:0] syncA;
    initial begin
        txIn = '0;
        txForceDispPin = 0;
        txDispValPin = 0;
        syncA = '0;
        {rmFullSync, rmEmptySync} = '0;
    end
    always @(posedge core_clk) begin
        txIn.valid <= sendReq;
        txIn.datak <= simpOn & isCtrl;
        // idle word shows a changing pattern, not the last one
        txIn.par <= !sendReq ? ~txIn.par : simpOn ? 16'h00A5 :
            {5'h00, wantNeg, forceOn, isCtrl, 8'hA5};
        txIn.unbal <= flip;
        txForceDispPin <= simpOn & forceOn;
        txDispValPin <= wantNeg;
        syncA <= {rmFullAsync, rmEmptyAsync};
        {rmFullSync, rmEmptySync} <= syncA;
    end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sendReq = 0, simpOn = 0, isCtrl = 0;
    logic forceOn = 0, wantNeg = 0, flip = 0;
    logic [pcsb_pkg::AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrbV = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, txForceDispPin;
    logic txDispValPin, rxValid, rxDispGenEn, txValidOut, txCtrlFlag;
    logic txRunDispPos, irq;
    logic [1:0] bresp, rresp, rs;
    pcsb_pkg::pcsb_rxblk_s rxIn = '0;
    pcsb_pkg::pcsb_rmin_s rmIn = '0;
    pcsb_pkg::pcsb_txin_s txIn;
    logic [63:0] rxData;
    logic [9:0] rxControl;
    logic [15:0] rxParallel;
    logic [pcsb_pkg::NLANE-1:0] rmFull, rmEmpty, rmFullS, rmEmptyS;
    logic [2*pcsb_pkg::NLANE-1:0] rmStatus;
    int n_fail = 0, checked = 0;
    pcsb_core dut (.core_clk(core_clk), .nrst(nrst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrbV), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .rxIn(rxIn),
        .rmIn(rmIn), .txIn(txIn), .txForceDispPin(txForceDispPin),
        .txDispValPin(txDispValPin), .rxValid(rxValid), .rxData(rxData),
        .rxControl(rxControl), .rxParallel(rxParallel),
        .rxDispGenEn(rxDispGenEn), .rmFull(rmFull), .rmEmpty(rmEmpty),
        .rmStatus(rmStatus), .txValidOut(txValidOut),
        .txCtrlFlag(txCtrlFlag), .txRunDispPos(txRunDispPos), .irq(irq));
    pcsb_fabric_model fab (.core_clk(core_clk), .sendReq(sendReq),
        .simpOn(simpOn), .isCtrl(isCtrl), .forceOn(forceOn),
        .wantNeg(wantNeg), .flip(flip), .rmFullAsync(rmFull),
        .rmEmptyAsync(rmEmpty), .txIn(txIn),
        .txForceDispPin(txForceDispPin), .txDispValPin(txDispValPin),
        .rmFullSync(rmFullS), .rmEmptySync(rmEmptyS));
    initial forever #25 core_clk = ~core_clk;
    task chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        repeat (40) if (!done) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin
                bready <= 0;
                r = bresp;
                done = 1;
            end
        end
        if (!done) chk(0, "no write response");
    endtask
    task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        repeat (40) if (!done) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) begin
                rready <= 0;
                d = rdata;
                r = rresp;
                done = 1;
            end
        end
        if (!done) chk(0, "no read data");
    endtask
    task rxw(input logic [1:0] h, input logic v);
        @(posedge core_clk);
        rxIn <= '{valid: 1, payload: 64'h0123456789ABCDEF, hdr: h, inv: v};
        @(posedge core_clk);
        rxIn.valid <= 0;
        rxIn.payload <= ~rxIn.payload;
        #1;
    endtask
    task t_reset;
        for (int k = 0; k < 4; k++) begin
            axr(4'(4 * k), rd, rs);
            chk(rd === 32'h0 && rs === pcsb_pkg::RESP_OKAY, "reset value");
        end
        axr(4'h2, rd, rs);
        chk(rd === 32'h0 && rs === pcsb_pkg::RESP_SLVERR, "unmapped read");
        axw(4'h6, 32'h1, rs);
        chk(rs === pcsb_pkg::RESP_SLVERR, "unmapped write");
        wstrbV <= 4'h0;
        axw(pcsb_pkg::ADDR_CTRL, 32'h7, rs);
        chk(rs === pcsb_pkg::RESP_OKAY, "strobe-off write response");
        wstrbV <= 4'hF;
        axr(pcsb_pkg::ADDR_CTRL, rd, rs);
        chk(rd === 32'h0, "strobe-off write ignored");
    endtask
    task t_rx66;
        rxw(pcsb_pkg::HDR_DATA, 0);
        chk(rxValid === 1 && rxData === 64'h0123456789ABCDEF, "data");
        chk(rxControl === 10'h001, "data header");
        rxw(pcsb_pkg::HDR_CTRL, 0);
        chk(rxControl === 10'h002, "control header");
        rxw(2'h3, 0);
        chk(rxControl === 10'h103, "header error");
        tick(2);
        chk(irq === 0, "irq masked");
        axr(pcsb_pkg::ADDR_IRQ, rd, rs);
        chk(rd === 32'h1, "irq status");
        axw(pcsb_pkg::ADDR_MASK, 32'h1F, rs);
        tick(2);
        chk(irq === 1, "irq raise");
        axw(pcsb_pkg::ADDR_IRQ, 32'h1, rs);
        tick(2);
        chk(irq === 0, "irq cleared");
    endtask
    task t_rx67;
        axw(pcsb_pkg::ADDR_CTRL, 32'h1, rs);
        rxw(pcsb_pkg::HDR_DATA, 0);
        chk(rxControl[2:0] === 3'h1 && rxDispGenEn, "inv low");
        axr(pcsb_pkg::ADDR_STAT, rd, rs);
        chk(rd[0] === 1, "status gen");
        rxw(pcsb_pkg::HDR_CTRL, 1);
        chk(rxControl[2:0] === 3'h6 && !rxDispGenEn, "inv high");
    endtask
    task rmr(input logic [7:0] v, input logic [3:0] e);
        @(posedge core_clk);
        rmIn <= v;
        tick(2);
        chk(rmStatus === e && {rmFull, rmEmpty} === v[7:4], "rate match");
    endtask
    task t_rate;
        axw(pcsb_pkg::ADDR_CTRL, 32'h2, rs);
        rmr(8'h00, 4'h0);
        rmr(8'h84, 4'hD);
        rmr(8'h62, 4'hB);
        tick(3);
        chk(rmFullS === 2'h1 && rmEmptyS === 2'h2, "synced");
        rxw(pcsb_pkg::HDR_DATA, 0);
        chk(rxParallel[14:13] === pcsb_pkg::RM_FULL, "status in word");
        axw(pcsb_pkg::ADDR_CTRL, 32'h0, rs);
        tick(2);
        chk(rmFull === 2'h0 && rmEmpty === 2'h0, "flags off");
        chk(irq === 1, "irq rate events");
        axr(pcsb_pkg::ADDR_IRQ, rd, rs);
        chk(rd === 32'h16, "rate event status");
        axw(pcsb_pkg::ADDR_IRQ, 32'h1F, rs);
        tick(2);
        chk(irq === 0, "irq all cleared");
    endtask
    task txr(input logic [4:0] s, input logic [1:0] e);
        @(posedge core_clk);
        {simpOn, isCtrl, forceOn, wantNeg, flip} <= s;
        tick(4);
        sendReq <= 1;
        @(posedge core_clk);
        sendReq <= 0;
        tick(1);
        chk(txValidOut === 1 && {txCtrlFlag, txRunDispPos} === e, "tx word");
    endtask
    task t_tx;
        txr(5'b01100, 2'b11);
        txr(5'b00110, 2'b00);
        txr(5'b00001, 2'b01);
        txr(5'b00000, 2'b01);
        axw(pcsb_pkg::ADDR_CTRL, 32'h4, rs);
        txr(5'b11110, 2'b10);
        txr(5'b10001, 2'b01);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1;
        t_reset;
        t_rx66;
        t_rx67;
        t_rate;
        t_tx;
        print_verdict;
    end
    initial begin
        #2000000;
        n_fail++;
        print_verdict;
    end
endmodule

// ==== src/pcsb_core.sv ====
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pcsb_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [pcsb_pkg::AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [pcsb_pkg::AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire pcsb_pkg::pcsb_rxblk_s rxIn,
    input wire pcsb_pkg::pcsb_rmin_s rmIn,
    input wire pcsb_pkg::pcsb_txin_s txIn,
    input wire logic txForceDispPin,
    input wire logic txDispValPin,
    output logic rxValid,
    output logic [63:0] rxData,
    output logic [9:0] rxControl,
    output logic [15:0] rxParallel,
    output logic rxDispGenEn,
    output logic [pcsb_pkg::NLANE-1:0] rmFull,
    output logic [pcsb_pkg::NLANE-1:0] rmEmpty,
    output logic [2*pcsb_pkg::NLANE-1:0] rmStatus,
    output logic txValidOut,
    output logic txCtrlFlag,
    output logic txRunDispPos,
    output logic irq
);
    localparam int NL = pcsb_pkg::NLANE;

    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wData_ff;
    logic [3:0] wStrb_ff;
    logic [pcsb_pkg::AW-1:0] awAddr_ff;
    logic [2:0] cfg_ff;
    logic [pcsb_pkg::IRQ_W-1:0] irqSt_ff, irqMask_ff, nxt_irqSt;
    logic irq_ff;
    logic [1:0] fdSync_ff, dvSync_ff;
    logic rxValid_ff, rxDispGenEn_ff;
    logic [63:0] rxData_ff;
    logic [9:0] rxControl_ff, nxt_rxControl;
    logic [15:0] rxParallel_ff;
    logic [NL-1:0] rmFull_ff, rmEmpty_ff;
    logic [2*NL-1:0] rmStatus_ff, rmCode;
    logic txValid_ff, txCtrl_ff, txRunDispPos_ff;

    // write takes place once both address and data are held
    wire awHeld = !awready_ff;
    wire wHeld = !wready_ff;
    wire doWr = awHeld && wHeld && !bvalid_ff;
    wire wrLane0 = wStrb_ff[0];
    wire wrCtrl = doWr && wrLane0 && awAddr_ff == pcsb_pkg::ADDR_CTRL;
    wire wrIrq = doWr && wrLane0 && awAddr_ff == pcsb_pkg::ADDR_IRQ;
    wire wrMask = doWr && wrLane0 && awAddr_ff == pcsb_pkg::ADDR_MASK;
    wire wrHit = awAddr_ff == pcsb_pkg::ADDR_CTRL
        || awAddr_ff == pcsb_pkg::ADDR_STAT
        || awAddr_ff == pcsb_pkg::ADDR_IRQ
        || awAddr_ff == pcsb_pkg::ADDR_MASK;
    wire arTake = arvalid && arready_ff;

    wire [1:0] mode = cfg_ff[1:0];
    wire simpEn = cfg_ff[pcsb_pkg::CFG_SIMP_BIT];
    wire isB67 = mode == pcsb_pkg::MODE_B67;
    wire isGige = mode == pcsb_pkg::MODE_GIGE;

    // sync header neither data nor control
    wire hdrBad = rxIn.hdr != pcsb_pkg::HDR_DATA
        && rxIn.hdr != pcsb_pkg::HDR_CTRL;
    wire hdrErr = rxIn.valid && !isGige && hdrBad;

    // transmit sideband source follows the simplified interface setting
    wire txCtrlSel = simpEn ? txIn.datak
        : txIn.par[pcsb_pkg::PAR_CTRL_BIT];
    wire txForce = simpEn ? fdSync_ff[1] : txIn.par[pcsb_pkg::PAR_FDISP_BIT];
    wire txDval = simpEn ? dvSync_ff[1] : txIn.par[pcsb_pkg::PAR_DVAL_BIT];

    wire [31:0] statWord = {24'h0, txRunDispPos_ff, rmStatus_ff[1:0],
        rmEmpty_ff, rmFull_ff, rxDispGenEn_ff};
    wire rdHit = araddr == pcsb_pkg::ADDR_CTRL
        || araddr == pcsb_pkg::ADDR_STAT
        || araddr == pcsb_pkg::ADDR_IRQ
        || araddr == pcsb_pkg::ADDR_MASK;
    wire [31:0] rdWord =
        araddr == pcsb_pkg::ADDR_CTRL ? {29'h0, cfg_ff} :
        araddr == pcsb_pkg::ADDR_STAT ? statWord :
        araddr == pcsb_pkg::ADDR_IRQ ? {27'h0, irqSt_ff} :
        araddr == pcsb_pkg::ADDR_MASK ? {27'h0, irqMask_ff} : 32'h0;

    // per-lane rate-match flags, events and status code
    logic [NL-1:0] fullRise, emptyRise;
    genvar i;
    generate
        for (i = 0; i < NL; i++) begin : g_lane
            assign fullRise[i] = isGige && rmIn.full[i] && !rmFull_ff[i];
            assign emptyRise[i] = isGige && rmIn.empty[i] && !rmEmpty_ff[i];
            assign rmCode[2*i+:2] =
                rmIn.del[i] ? pcsb_pkg::RM_DELETE :
                rmIn.ins[i] ? pcsb_pkg::RM_INSERT :
                rmIn.full[i] ? pcsb_pkg::RM_FULL :
                pcsb_pkg::RM_NORMAL;
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    rmFull_ff[i] <= 1'b0;
                    rmEmpty_ff[i] <= 1'b0;
                    rmStatus_ff[2*i+:2] <= pcsb_pkg::RM_NORMAL;
                end else begin
                    rmFull_ff[i] <= isGige && rmIn.full[i];
                    rmEmpty_ff[i] <= isGige && rmIn.empty[i];
                    rmStatus_ff[2*i+:2] <= rmCode[2*i+:2];
                end
            end
        end
    endgenerate

    // set wins over write-one-to-clear
    wire [pcsb_pkg::IRQ_W-1:0] irqEvt = {emptyRise, fullRise, hdrErr};
    wire [pcsb_pkg::IRQ_W-1:0] irqClr =
        wrIrq ? wData_ff[pcsb_pkg::IRQ_W-1:0] : 5'h00;
    assign nxt_irqSt = (irqSt_ff & ~irqClr) | irqEvt;

    always_comb begin
        nxt_rxControl = 10'h000;
        nxt_rxControl[1:0] = rxIn.hdr;
        if (isB67) begin
            nxt_rxControl[pcsb_pkg::CTL_INV_BIT] = rxIn.inv;
        end else begin
            nxt_rxControl[pcsb_pkg::CTL_ERR_BIT] = hdrBad;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= pcsb_pkg::RESP_OKAY;
            awAddr_ff <= '0;
            wData_ff <= 32'h0;
            wStrb_ff <= 4'h0;
        end else begin
            if (awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                awAddr_ff <= awaddr;
            end else if (bvalid_ff && bready) begin
                awready_ff <= 1'b1;
            end
            if (wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end else if (bvalid_ff && bready) begin
                wready_ff <= 1'b1;
            end
            if (doWr) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wrHit ? pcsb_pkg::RESP_OKAY
                    : pcsb_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= pcsb_pkg::RESP_OKAY;
        end else if (arTake) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rdWord;
            rresp_ff <= rdHit ? pcsb_pkg::RESP_OKAY : pcsb_pkg::RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_ff <= pcsb_pkg::CFG_RESET;
            irqMask_ff <= pcsb_pkg::IRQ_RESET;
            irqSt_ff <= pcsb_pkg::IRQ_RESET;
            irq_ff <= 1'b0;
            fdSync_ff <= 2'h0;
            dvSync_ff <= 2'h0;
        end else begin
            if (wrCtrl) begin
                cfg_ff <= wData_ff[2:0];
            end
            if (wrMask) begin
                irqMask_ff <= wData_ff[pcsb_pkg::IRQ_W-1:0];
            end
            irqSt_ff <= nxt_irqSt;
            irq_ff <= |(nxt_irqSt & irqMask_ff);
            fdSync_ff <= {fdSync_ff[0], txForceDispPin};
            dvSync_ff <= {dvSync_ff[0], txDispValPin};
        end
    end
    // receive word assembly
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rxValid_ff <= 1'b0;
            rxData_ff <= 64'h0;
            rxControl_ff <= 10'h000;
            rxParallel_ff <= 16'h0000;
            rxDispGenEn_ff <= 1'b0;
        end else begin
            rxValid_ff <= rxIn.valid;
            if (rxIn.valid) begin
                rxData_ff <= rxIn.payload;
                rxControl_ff <= nxt_rxControl;
                rxParallel_ff <= simpEn ? rxIn.payload[15:0]
                    : {rxIn.payload[15], rmCode[1:0],
                    rxIn.payload[12:0]};
                rxDispGenEn_ff <= isB67 && !rxIn.inv;
            end
        end
    end

    // transmit control flag and running disparity
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            txValid_ff <= 1'b0;
            txCtrl_ff <= 1'b0;
            txRunDispPos_ff <= 1'b0;
        end else begin
            txValid_ff <= txIn.valid;
            if (txIn.valid) begin
                txCtrl_ff <= txCtrlSel;
                if (txForce) begin
                    txRunDispPos_ff <= !txDval;
                end else begin
                    txRunDispPos_ff <= txRunDispPos_ff ^ txIn.unbal;
                end
            end
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign rxValid = rxValid_ff;
    assign rxData = rxData_ff;
    assign rxControl = rxControl_ff;
    assign rxParallel = rxParallel_ff;
    assign rxDispGenEn = rxDispGenEn_ff;
    assign rmFull = rmFull_ff;
    assign rmEmpty = rmEmpty_ff;
    assign rmStatus = rmStatus_ff;
    assign txValidOut = txValid_ff;
    assign txCtrlFlag = txCtrl_ff;
    assign txRunDispPos = txRunDispPos_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_hdr_passed: assert property (
        rxIn.valid |=> rxControl[1:0] == $past(rxIn.hdr))
        else $error("sync header not passed to control bits");
    a_unused_zero: assert property (
        rxIn.valid && !isB67 && !isGige
        |=> rxControl[7:2] == 6'h00 && rxControl[8] == $past(hdrBad))
        else $error("66-bit control word layout wrong");
    a_inv_flag: assert property (
        rxIn.valid && isB67 |=> rxControl[2] == $past(rxIn.inv))
        else $error("inversion flag not on control bit 2");
    a_disp_gen: assert property (
        rxIn.valid && isB67 && !rxIn.inv ##1 !rxIn.valid
        |=> rxDispGenEn && $stable(rxDispGenEn))
        else $error("disparity generator not selected");
    a_full_gige: assert property (
        !isGige |=> rmFull == '0)
        else $error("full flag outside gigabit mode");
    a_empty_track: assert property (
        isGige && $stable(cfg_ff) |=> rmEmpty == $past(rmIn.empty))
        else $error("empty flag does not follow fifo");
    a_rm_code: assert property (
        rmIn.del[0] |=> rmStatus[1:0] == 2'h1)
        else $error("deletion status code wrong");
    a_par_status: assert property (
        rxIn.valid && !simpEn |=> rxParallel[14:13] == rmStatus[1:0])
        else $error("rate-match status missing from parallel word");
    a_ctrl_bit8: assert property (
        txIn.valid && !simpEn
        |=> txCtrlFlag == $past(txIn.par[8]) && txValidOut)
        else $error("control flag not taken from bit 8");
    a_force_disp: assert property (
        txIn.valid && txForce |=> txRunDispPos == !$past(txDval))
        else $error("forced disparity not applied");
    a_irq_level: assert property (
        irq |-> $past(|(nxt_irqSt & irqMask_ff)))
        else $error("interrupt without unmasked cause");
endmodule

// ==== src/pcsb_pkg.sv ====
package pcsb_pkg;
    localparam int NLANE = 2;
    localparam int AW = 4;
    localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [AW-1:0] ADDR_STAT = 4'h4;
    localparam logic [AW-1:0] ADDR_IRQ = 4'h8;
    localparam logic [AW-1:0] ADDR_MASK = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] HDR_DATA = 2'h1;
    localparam logic [1:0] HDR_CTRL = 2'h2;
    localparam logic [1:0] RM_NORMAL = 2'h0;
    localparam logic [1:0] RM_DELETE = 2'h1;
    localparam logic [1:0] RM_INSERT = 2'h2;
    localparam logic [1:0] RM_FULL = 2'h3;
    localparam int CTL_INV_BIT = 2;
    localparam int CTL_ERR_BIT = 8;
    localparam int PAR_RM_LSB = 13;
    localparam int PAR_CTRL_BIT = 8;
    localparam int PAR_FDISP_BIT = 9;
    localparam int PAR_DVAL_BIT = 10;
    localparam int CFG_SIMP_BIT = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam int IRQ_W = 1 + 2 * NLANE;
    localparam int IRQ_HDR = 0;
    localparam int IRQ_FULL_LSB = 1;
    localparam int IRQ_EMPTY_LSB = 1 + NLANE;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

    typedef enum logic [1:0] {
        MODE_B66,
        MODE_B67,
        MODE_GIGE
    } pcsb_mode_e;

    typedef struct packed {
        logic valid;
        logic [63:0] payload;
        logic [1:0] hdr;
        logic inv;
    } pcsb_rxblk_s;

    typedef struct packed {
        logic valid;
        logic [15:0] par;
        logic datak;
        logic unbal;
    } pcsb_txin_s;

    typedef struct packed {
        logic [NLANE-1:0] full;
        logic [NLANE-1:0] empty;
        logic [NLANE-1:0] del;
        logic [NLANE-1:0] ins;
    } pcsb_rmin_s;
endpackage
